// File: logic/imt_timer.sv
// Purpose : Two-channel interval match timer behind an APB slave.
// Assumes : APB4 with pstrb; zero wait state; presetn is power-on reset.
// Notes   : Standby reinitialises the timer registers synchronously.
//           Word map, byte address four times the index:
//             0x00 run, 0x04/0x10 control, 0x08/0x14 count,
//             0x0c/0x18 period, channel 0 then channel 1.
//           Read data is captured at the setup edge, so a running
//           count may read one tick old.
//           Only strobe lanes 0 and 1 reach a register.
//
// Summary of operation
// RULE1: two channels, 16-bit counter and period
// RULE2: per-channel choice of four divided rates
// RULE3: select 00/01/10/11 gives div 8/32/128/512
// RULE4: shared run bits, bit0 ch0, bit1 ch1
// RULE5: running counter increments on selected tick
// RULE6: equality clears counter, sets match flag
// RULE7: match flag bit 7, sticky
// RULE8: flag clears by write 0 after read 1
// RULE9: bit 6 enables the match interrupt
// RULE10: separate interrupt request per channel
// RULE11: counter is software readable and writable
// RULE12: period register readable, writable, sets interval
// RULE13: run, control, counter zero on reset, standby
// RULE14: period all ones on reset, standby
// RULE15: reserved bits read zero
// RULE16: 8, 16 and 32-bit accesses accepted
// RULE17: match acts on tick after equality
// RULE18: match beats a counter write
// RULE19: word write beats an increment
// RULE20: byte write keeps other byte, no increment
// RULE21: interrupt level while flag and enable set

`timescale 1ns/10ps

module imt_timer
   import imt_pkg::*;
(
   input  wire logic                    pclk,
   input  wire logic                    presetn,
   input  wire logic                    standby,
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [IMT_ADDR_W-1:0]   paddr,
   input  wire logic [IMT_DATA_W-1:0]   pwdata,
   input  wire logic [IMT_STRB_W-1:0]   pstrb,
   output logic      [IMT_DATA_W-1:0]   prdata,
   output logic                         pready,
   output logic                         pslverr,
   output logic      [IMT_CHANNELS-1:0] match_irq
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [IMT_CHANNELS-1:0]  run;
      imt_chan_type [IMT_CHANNELS-1:0] ch;
      logic [IMT_CHANNELS-1:0]  irq;
      logic [IMT_DATA_W-1:0]    rdata;
      logic                     ready;
      logic                     err;
   } imt_state_type;

   imt_state_type st;
   imt_state_type next_st;

   logic [IMT_RATES-1:0] tick;

   // ---------------------------------------------------------------
   // Prescaler
   // ---------------------------------------------------------------
   imt_prescaler #(
      .PRE_W   (IMT_PRE_W)
   ) u_prescaler (
      .pclk    (pclk),
      .presetn (presetn),
      .standby (standby),
      .tick    (tick)
   );

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // Byte-lane merge; a lane left unstrobed keeps its old value
   function automatic logic [15:0] imt_merge(
      input logic [15:0]           old_val,
      input logic [IMT_DATA_W-1:0] wdata,
      input logic [IMT_STRB_W-1:0] strb
   );
      logic [15:0] res;
      res = old_val;
      if (strb[IMT_LANE_LO])
      begin
         res[7:0] = wdata[7:0];
      end
      if (strb[IMT_LANE_HI])
      begin
         res[15:8] = wdata[15:8];
      end
      return res;
   endfunction

   function automatic logic [15:0] imt_csr_view(input imt_chan_type c);
      logic [15:0] v;
      v = '0;  // RULE15
      v[IMT_CSR_FLAG] = c.match_flag;
      v[IMT_CSR_IE]   = c.match_irq_enable;
      v[IMT_CSR_CKS +: IMT_CKS_W] = c.clk_sel;
      return v;
   endfunction

   // ---------------------------------------------------------------
   // Bus decode
   // ---------------------------------------------------------------
   logic       setup;
   logic       access;
   logic       hit;
   logic [2:0] idx;
   logic       wr;
   logic       rd;

   always_comb
   begin
      idx    = paddr[4:2];
      hit    = (paddr[1:0] == 2'h0) && (idx <= IMT_IDX_LAST);
      setup  = psel & ~penable;
      access = psel & penable & st.ready;
      wr     = access & pwrite & hit;  // RULE16
      rd     = access & ~pwrite & hit;
   end

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   logic [15:0]             rview;
   logic [IMT_CHANNELS-1:0] match;
   logic [IMT_CHANNELS-1:0] chan_tick;
   logic [IMT_CHANNELS-1:0] csr_hit;
   logic [IMT_CHANNELS-1:0] cnt_hit;
   logic [IMT_CHANNELS-1:0] per_hit;
   logic [IMT_CHANNELS-1:0] csr_rd;

   // ---------------------------------------------------------------
   // Per-channel decode
   // ---------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < IMT_CHANNELS; g++)
      begin : g_chan
         localparam logic [2:0] CSR_IDX =
            3'(IMT_IDX_CSR0 + 3'(g) * IMT_IDX_STEP);
         localparam logic [2:0] CNT_IDX =
            3'(CSR_IDX + IMT_IDX_CNT0 - IMT_IDX_CSR0);
         localparam logic [2:0] PER_IDX =
            3'(CSR_IDX + IMT_IDX_PER0 - IMT_IDX_CSR0);

         assign csr_hit[g] = wr & (idx == CSR_IDX);
         assign cnt_hit[g] = wr & (idx == CNT_IDX);
         assign per_hit[g] = wr & (idx == PER_IDX);
         // Only a read that returned the flag as 1 arms its clear
         assign csr_rd[g]  = rd & (idx == CSR_IDX)
                           & st.rdata[IMT_CSR_FLAG];  // RULE8
         // Tick from the channel's own rate
         assign chan_tick[g] = tick[st.ch[g].clk_sel]
                             & st.run[g];  // RULE2 RULE3 RULE5
         // Equality is acted on only at the following tick
         assign match[g] = chan_tick[g]
                         & (st.ch[g].count == st.ch[g].period);  // RULE17
      end
   endgenerate

   always_comb
   begin
      next_st = st;
      rview   = '0;

      // Run bits
      if (wr && idx == IMT_IDX_RUN && pstrb[IMT_LANE_LO])
      begin
         next_st.run = pwdata[IMT_CHANNELS-1:0];  // RULE4
      end

      for (int c = 0; c < IMT_CHANNELS; c++)
      begin
         // Counter
         if (match[c])
         begin
            next_st.ch[c].count = IMT_CNT_RESET;  // RULE6 RULE18
         end
         else if (cnt_hit[c])
         begin
            next_st.ch[c].count =
               imt_merge(st.ch[c].count, pwdata, pstrb);  // RULE19 RULE20
         end
         else if (chan_tick[c])
         begin
            next_st.ch[c].count = st.ch[c].count + 16'h0001;  // RULE1 RULE11
         end

         // Period
         if (per_hit[c])
         begin
            next_st.ch[c].period =
               imt_merge(st.ch[c].period, pwdata, pstrb);  // RULE12
         end

         // Control and flag
         if (csr_hit[c] && pstrb[IMT_LANE_LO])
         begin
            next_st.ch[c].match_irq_enable = pwdata[IMT_CSR_IE];  // RULE9
            next_st.ch[c].clk_sel =
               pwdata[IMT_CSR_CKS +: IMT_CKS_W];  // RULE3
            // Only a 0 after a read of 1 clears; writing 1 does nothing
            if (st.ch[c].flag_seen && !pwdata[IMT_CSR_FLAG])
            begin
               next_st.ch[c].match_flag = 1'b0;  // RULE8
            end
            next_st.ch[c].flag_seen = 1'b0;
         end
         else if (csr_rd[c])
         begin
            next_st.ch[c].flag_seen = 1'b1;  // RULE8
         end

         // Set wins over a clear in the same cycle
         if (match[c])
         begin
            next_st.ch[c].match_flag = 1'b1;  // RULE6 RULE7
         end
      end

      // Standby reinitialises the timer, not the bus side
      if (standby)
      begin
         next_st.run = '0;  // RULE13
         for (int c = 0; c < IMT_CHANNELS; c++)
         begin
            next_st.ch[c] = IMT_CHAN_RESET;  // RULE13 RULE14
         end
      end

      // Interrupt level follows the registered flag and enable
      for (int c = 0; c < IMT_CHANNELS; c++)
      begin
         next_st.irq[c] = next_st.ch[c].match_flag
                        & next_st.ch[c].match_irq_enable;  // RULE10 RULE21
      end

      // Read data captured at setup; answer in the access cycle
      unique case (idx)
         IMT_IDX_RUN:
         begin
            rview = 16'(st.run);  // RULE15
         end
         IMT_IDX_CSR0:
         begin
            rview = imt_csr_view(st.ch[0]);
         end
         IMT_IDX_CNT0:
         begin
            rview = st.ch[0].count;
         end
         IMT_IDX_PER0:
         begin
            rview = st.ch[0].period;
         end
         3'(IMT_IDX_CSR0 + IMT_IDX_STEP):
         begin
            rview = imt_csr_view(st.ch[1]);
         end
         3'(IMT_IDX_CNT0 + IMT_IDX_STEP):
         begin
            rview = st.ch[1].count;
         end
         3'(IMT_IDX_PER0 + IMT_IDX_STEP):
         begin
            rview = st.ch[1].period;
         end
         default:
         begin
            rview = '0;
         end
      endcase

      next_st.ready = setup;
      if (setup)
      begin
         next_st.rdata = (hit && !pwrite) ? {16'h0000, rview} : '0;
         next_st.err   = ~hit;
      end
      else if (access)
      begin
         next_st.err = 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st.run   <= '0;  // RULE13
         for (int c = 0; c < IMT_CHANNELS; c++)
         begin
            st.ch[c] <= IMT_CHAN_RESET;  // RULE13 RULE14
         end
         st.irq   <= '0;
         st.rdata <= '0;
         st.ready <= 1'b0;
         st.err   <= 1'b0;
      end
      else
      begin
         st <= next_st;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign prdata    = st.rdata;
   assign pready    = st.ready;
   assign pslverr   = st.err;
   assign match_irq = st.irq;

endmodule

// File: logic/imt_pkg.sv
// Purpose : Shared constants and types for the interval match timer.
// Assumes : APB slave, 32-bit data, 16-bit registers in the low half.
// Notes   : Printed offsets are halfword spaced; each becomes an index,
//           and the APB byte address is four times that index.

package imt_pkg;

   // ---------------------------------------------------------------
   // Geometry
   // ---------------------------------------------------------------
   localparam int unsigned IMT_CHANNELS  = 2;
   localparam int unsigned IMT_CNT_W     = 16;
   localparam int unsigned IMT_ADDR_W    = 5;
   localparam int unsigned IMT_DATA_W    = 32;
   localparam int unsigned IMT_STRB_W    = 4;
   localparam int unsigned IMT_CKS_W     = 2;
   localparam int unsigned IMT_RATES     = 4;
   localparam int unsigned IMT_PRE_W     = 9;

   // ---------------------------------------------------------------
   // Prescaler: divide by 8, 32, 128, 512 as powers of two
   // ---------------------------------------------------------------
   localparam int unsigned IMT_DIV_LOG [IMT_RATES] = '{3, 5, 7, 9};

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [31:0] IMT_OFS_BASE  = 32'hffff83d0;
   localparam logic [31:0] IMT_OFS_RUN   = 32'hffff83d0;
   localparam logic [31:0] IMT_OFS_CSR0  = 32'hffff83d2;
   localparam logic [31:0] IMT_OFS_CNT0  = 32'hffff83d4;
   localparam logic [31:0] IMT_OFS_PER0  = 32'hffff83d6;
   localparam logic [31:0] IMT_OFS_CSR1  = 32'hffff83d8;
   localparam logic [31:0] IMT_OFS_CNT1  = 32'hffff83da;
   localparam logic [31:0] IMT_OFS_PER1  = 32'hffff83dc;

   localparam logic [2:0]  IMT_IDX_RUN   =
      3'((IMT_OFS_RUN  - IMT_OFS_BASE) >> 1);
   localparam logic [2:0]  IMT_IDX_CSR0  =
      3'((IMT_OFS_CSR0 - IMT_OFS_BASE) >> 1);
   localparam logic [2:0]  IMT_IDX_CNT0  =
      3'((IMT_OFS_CNT0 - IMT_OFS_BASE) >> 1);
   localparam logic [2:0]  IMT_IDX_PER0  =
      3'((IMT_OFS_PER0 - IMT_OFS_BASE) >> 1);
   localparam logic [2:0]  IMT_IDX_LAST  =
      3'((IMT_OFS_PER1 - IMT_OFS_BASE) >> 1);
   localparam logic [2:0]  IMT_IDX_STEP  =
      3'((IMT_OFS_CSR1 - IMT_OFS_CSR0) >> 1);

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int unsigned IMT_CSR_FLAG  = 7;
   localparam int unsigned IMT_CSR_IE    = 6;
   localparam int unsigned IMT_CSR_CKS   = 0;
   localparam int unsigned IMT_LANE_LO   = 0;
   localparam int unsigned IMT_LANE_HI   = 1;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [15:0] IMT_CNT_RESET = 16'h0000;
   localparam logic [15:0] IMT_PER_RESET = 16'hffff;
   localparam logic [1:0]  IMT_CKS_RESET = 2'h0;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic        match_flag;
      logic        match_irq_enable;
      logic [1:0]  clk_sel;
      logic        flag_seen;
      logic [15:0] count;
      logic [15:0] period;
   } imt_chan_type;

   localparam imt_chan_type IMT_CHAN_RESET = '{
      match_flag       : 1'b0,
      match_irq_enable : 1'b0,
      clk_sel          : IMT_CKS_RESET,
      flag_seen        : 1'b0,
      count            : IMT_CNT_RESET,
      period           : IMT_PER_RESET
   };

endpackage

// File: logic/imt_prescaler.sv
// Purpose : Free-running divider giving one-cycle enables per rate.
// Assumes : Single clock domain, pclk.
// Notes   : Held in reset while standby is high.

`timescale 1ns/10ps

module imt_prescaler
   import imt_pkg::*;
#(
   parameter int unsigned PRE_W = IMT_PRE_W
)
(
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 standby,
   output logic      [IMT_RATES-1:0] tick
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [PRE_W-1:0]     cnt;
      logic [IMT_RATES-1:0] tick;
   } imt_pre_state_type;

   imt_pre_state_type st;
   imt_pre_state_type next_st;

   logic [IMT_RATES-1:0] wrap;

   // ---------------------------------------------------------------
   // Rate taps
   // ---------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < IMT_RATES; g++)
      begin : g_rate
         // Pulse once every 2**log cycles
         assign wrap[g] = &st.cnt[IMT_DIV_LOG[g]-1:0];
      end
   endgenerate

   always_comb
   begin
      next_st = st;
      if (standby)
      begin
         next_st = '0;
      end
      else
      begin
         next_st.cnt  = st.cnt + 1'b1;
         next_st.tick = wrap;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign tick = st.tick;

endmodule

// File: dv/imt_timer_asserts.sv
// Purpose: Port checks for imt_timer.
// Assumes: One access cycle per APB transfer.
// Notes: Bound into every imt_timer instance.
`timescale 1ns/10ps
module imt_timer_asserts
   import imt_pkg::*;
(
   input wire logic                    pclk,
   input wire logic                    presetn,
   input wire logic                    standby,
   input wire logic                    psel,
   input wire logic                    penable,
   input wire logic                    pwrite,
   input wire logic [IMT_ADDR_W-1:0]   paddr,
   input wire logic [IMT_DATA_W-1:0]   prdata,
   input wire logic                    pready,
   input wire logic                    pslverr,
   input wire logic [IMT_CHANNELS-1:0] match_irq
);
   default clocking dc @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_ready_next: assert property (psel && !penable |=> pready)
      else $error("ready missing after setup");
   chk_ready_only: assert property (pready |->
      psel && penable && $past(psel && !penable))
      else $error("ready outside access");
   chk_err_bad: assert property (pready &&
      (paddr[4:2] == 3'h7 || paddr[1:0] != 2'h0) |-> pslverr)
      else $error("bad address not refused");
   chk_err_good: assert property (pready &&
      paddr[4:2] != 3'h7 && paddr[1:0] == 2'h0 |-> !pslverr)
      else $error("good address refused");
   chk_rsv_run: assert property (pready && !pwrite &&
      paddr == 5'h00 |-> prdata[31:2] == 30'h0)
      else $error("run reserved bits set");
   chk_rsv_csr: assert property (pready && !pwrite &&
      (paddr == 5'h04 || paddr == 5'h10) |->
      prdata[31:8] == 24'h0 && prdata[5:2] == 4'h0)
      else $error("csr reserved bits set");
   chk_upper_zero: assert property (pready |->
      prdata[31:16] == 16'h0)
      else $error("upper half not zero");
   chk_stby_irq: assert property (standby |=> match_irq == 2'h0)
      else $error("irq survives standby");
   chk_irq0_fall: assert property ($fell(match_irq[0]) |->
      $past(standby || psel && penable && pwrite && paddr == 5'h04))
      else $error("irq0 fell without cause");
   chk_irq1_fall: assert property ($fell(match_irq[1]) |->
      $past(standby || psel && penable && pwrite && paddr == 5'h10))
      else $error("irq1 fell without cause");
endmodule

bind imt_timer imt_timer_asserts imt_timer_asserts_inst (.pclk(pclk),
   .presetn(presetn), .standby(standby), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .match_irq(match_irq));

// File: dv/imt_apb_master.sv
// Purpose: APB master standing in for the processor bus.
// Assumes: Caller enters xfer just after a rising edge.
// Notes: Released address and data lines are scrambled.
`timescale 1ns/10ps
module imt_apb_master
   import imt_pkg::*;
(
   input  wire logic                  pclk,
   input  wire logic                  pready,
   output logic                       psel,
   output logic                       penable,
   output logic                       pwrite,
   output logic      [IMT_ADDR_W-1:0] paddr,
   output logic      [IMT_DATA_W-1:0] pwdata,
   output logic      [IMT_STRB_W-1:0] pstrb
);
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      pstrb = '0;
   end
   task automatic xfer(input logic w, input logic [4:0] a,
      input logic [31:0] d, input logic [3:0] s, output logic ok);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 64);
      psel <= 1'b0;
      penable <= 1'b0;
      // Stale values must not look valid
      paddr <= ~a;
      pwdata <= ~d;
      pwrite <= ~w;
      pstrb <= ~s;
      ok = (n < 64);
      @(posedge pclk);
   endtask
endmodule

// File: dv/imt_timer_test.sv
// Purpose: Self-checking bench for imt_timer.
// Assumes: Bus answers within 64 cycles.
// Notes: Interval measured match to match, prescaler phase free.
`timescale 1ns/10ps
module imt_timer_test;
   import imt_pkg::*;
   typedef struct packed {
      logic [31:0] d;
      logic [31:0] m;
      logic        e;
   } imt_exp_type;
   localparam logic [4:0] A_RUN = {IMT_IDX_RUN, 2'b00};
   localparam logic [4:0] A_CSR0 = {IMT_IDX_CSR0, 2'b00};
   localparam logic [4:0] A_CNT0 = {IMT_IDX_CNT0, 2'b00};
   localparam logic [4:0] A_PER0 = {IMT_IDX_PER0, 2'b00};
   localparam logic [4:0] A_STEP = {IMT_IDX_STEP, 2'b00};
   logic        pclk = 1'b0;
   logic        presetn;
   logic        standby;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [4:0]  paddr;
   logic [31:0] pwdata;
   logic [3:0]  pstrb;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [1:0]  match_irq;
   int          err_count = 0;
   int          n_tests = 0;
   int          cyc = 0;
   imt_exp_type exp_q[$];
   imt_exp_type x;
   logic [15:0] r = 16'h004a;
   int          t0;
   int          t1;

   always #2 pclk = ~pclk;
   always @(posedge pclk) cyc <= cyc + 1;

   imt_timer imt_timer_inst (.pclk(pclk), .presetn(presetn),
      .standby(standby), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .match_irq(match_irq));
   imt_apb_master imt_apb_master_inst (.pclk(pclk), .pready(pready),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb));

   // ----
   // Checking
   // ----
   task automatic finish_test();
      if (err_count == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string s, input logic [31:0] e,
      input logic [31:0] v);
      n_tests++;
      if (v !== e)
      begin
         err_count++;
         $display("[ERR] %s exp %h seen %h", s, e, v);
      end
   endtask
   always @(posedge pclk)
   begin
      if (psel && penable && pready === 1'b1)
      begin
         n_tests++;
         x = exp_q.pop_front();
         if ({pslverr, prdata & x.m} !== {x.e, x.d & x.m})
         begin
            err_count++;
            $display("[ERR] apb %h exp %h seen %h", paddr,
               {x.e, x.d}, {pslverr, prdata});
         end
      end
   end

   // ----
   // Stimulus
   // ----
   function automatic logic [15:0] lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   task automatic xf(input logic w, input logic [4:0] a,
      input logic [15:0] d, input logic [3:0] s, input logic e);
      logic ok;
      exp_q.push_back({{16'h0, d}, (w ? 32'h0 : 32'hffffffff), e});
      imt_apb_master_inst.xfer(w, a, {16'h0, d}, s, ok);
      if (!ok)
      begin
         err_count++;
         finish_test();
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      xf(1'b1, a, d, 4'h3, 1'b0);
   endtask
   task automatic rd(input logic [4:0] a, input logic [15:0] d);
      xf(1'b0, a, d, 4'h0, 1'b0);
   endtask
   task automatic clr(input logic [4:0] a, input logic [15:0] v);
      rd(a, v | 16'h0080);
      wr(a, v);
   endtask
   task automatic wait_irq(input int c, output int t);
      int n;
      n = 0;
      while (match_irq[c] !== 1'b1 && n < 2000)
      begin
         @(posedge pclk);
         n++;
      end
      if (n == 2000)
      begin
         err_count++;
         finish_test();
      end
      t = cyc;
   endtask

   initial
   begin
      presetn = 1'b0;
      standby = 1'b0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(A_RUN, 16'h0);
      for (int c = 0; c < 2; c++)
      begin
         rd(A_CSR0 + (c ? A_STEP : 5'h0), 16'h0);
         rd(A_CNT0 + (c ? A_STEP : 5'h0), 16'h0);
         rd(A_PER0 + (c ? A_STEP : 5'h0), 16'hffff);
      end
      xf(1'b0, 5'h1c, 16'h0, 4'h0, 1'b1);
      xf(1'b1, 5'h09, 16'h0, 4'h3, 1'b1);
      r = lfsr(r);
      xf(1'b1, A_PER0, r, 4'hf, 1'b0);
      rd(A_PER0, r);
      xf(1'b1, A_PER0, ~r, 4'h2, 1'b0);
      rd(A_PER0, {~r[15:8], r[7:0]});
      xf(1'b1, A_CNT0, r, 4'h1, 1'b0);
      rd(A_CNT0, {8'h00, r[7:0]});
      wr(A_CSR0, 16'hffff);
      rd(A_CSR0, 16'h0043);
      wr(A_RUN, 16'hfffc);
      rd(A_RUN, 16'h0);
      wr(A_PER0, 16'h0002);
      for (int k = 0; k < 4; k++)
      begin
         wr(A_RUN, 16'h0);
         wr(A_CNT0, 16'h0);
         wr(A_CSR0, 16'h0040 + 16'(k));
         wr(A_RUN, 16'h0001);
         wait_irq(0, t0);
         clr(A_CSR0, 16'h0040 + 16'(k));
         wait_irq(0, t1);
         chk("interval", 32'(3 * (8 << (2 * k))), 32'(t1 - t0));
         clr(A_CSR0, 16'h0040 + 16'(k));
      end
      wr(A_PER0 + A_STEP, 16'h0);
      wr(A_RUN, 16'h0003);
      repeat (2 * 8) @(posedge pclk);
      chk("irq1 masked", 32'h0, 32'(match_irq[1]));
      wr(A_RUN, 16'h0001);
      wr(A_CSR0 + A_STEP, 16'h0040);
      chk("irq1 level", 32'h1, 32'(match_irq[1]));
      clr(A_CSR0 + A_STEP, 16'h0040);
      rd(A_CSR0 + A_STEP, 16'h0040);
      chk("irq1 off", 32'h0, 32'(match_irq[1]));
      r = lfsr(r);
      wr(A_PER0, r);
      standby <= 1'b1;
      repeat (2) @(posedge pclk);
      standby <= 1'b0;
      @(posedge pclk);
      rd(A_RUN, 16'h0);
      rd(A_CNT0, 16'h0);
      rd(A_PER0, 16'hffff);
      finish_test();
   end
endmodule
